// ==== design/adc_serial_config_port.sv ====
`timescale 1ns/100ps
`default_nettype none

module adc_serial_config_port
    import adc_cfg_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ser_clk,
    input wire logic i_ser_din,
    input wire logic i_ser_select_n,
    input wire logic i_ext_mode_n,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_calibration_control,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_output_configuration,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_chan_i_offset_trim,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_chan_i_fullscale_trim,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_extended_configuration,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_chan_q_offset_trim,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_chan_q_fullscale_trim,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_sample_phase_fine,
    output logic [adc_cfg_pkg::DATA_BITS-1:0] o_sample_phase_coarse_mid,
    output logic o_cal_start,
    output logic o_ext_active
);
    import adc_cfg_pkg::*;

    logic sclk_s;
    logic din_s;
    logic sel_n_s;
    logic ext_n_s;
    logic sclk_d;
    logic next_sclk_d;
    logic sclk_rise;
    frame_state_t state;
    frame_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [SHIFT_W-1:0] shift;
    logic [SHIFT_W-1:0] next_shift;
    logic frame_done;
    logic [FRAME_BITS-1:0] frame_word;
    logic [HDR_BITS-1:0] frame_hdr;
    logic [ADDR_BITS-1:0] frame_addr;
    logic [DATA_BITS-1:0] frame_data;
    logic [SLOT_W-1:0] frame_slot;
    logic frame_ok;
    logic [DATA_BITS-1:0] regs [0:NUM_REGS-1];
    logic [DATA_BITS-1:0] next_regs [0:NUM_REGS-1];
    logic next_cal_start;
    logic next_ext_active;

    // Every pin crosses from the host's world through two flip-flops.
    pin_sync #(.RESET_VAL(1'b0)) u_sync_clk (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_ser_clk),
        .o_level(sclk_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) u_sync_din (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_ser_din),
        .o_level(din_s)
    );
    pin_sync #(.RESET_VAL(1'b1)) u_sync_sel (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_ser_select_n),
        .o_level(sel_n_s)
    );
    pin_sync #(.RESET_VAL(1'b1)) u_sync_ext (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_ext_mode_n),
        .o_level(ext_n_s)
    );

    // Address decode; reserved addresses yield no storage slot.
    function automatic logic [SLOT_W-1:0] slot_of(
        input logic [ADDR_BITS-1:0] addr
    );
        logic [SLOT_W-1:0] s;
        s = NO_SLOT;
        unique case (addr)
            ADDR_CAL: s = SLOT_CAL;
            ADDR_CFG: s = SLOT_CFG;
            ADDR_I_OFS: s = SLOT_I_OFS;
            ADDR_I_FS: s = SLOT_I_FS;
            ADDR_EXT: s = SLOT_EXT;
            ADDR_Q_OFS: s = SLOT_Q_OFS;
            ADDR_Q_FS: s = SLOT_Q_FS;
            ADDR_PH_FINE: s = SLOT_PH_FINE;
            ADDR_PH_COARSE: s = SLOT_PH_COARSE;
            default: s = NO_SLOT;
        endcase
        return s;
    endfunction

    // Rising edge of the synchronised serial clock; data and select share
    // the same synchroniser delay, so they line up with the edge.
    assign sclk_rise = sclk_s & ~sclk_d;

    // Frame counter and shifter.  Counting wraps from the last bit to zero,
    // so a held-low select keeps framing by edges alone.
    always_comb
    begin
        next_sclk_d = sclk_s;
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        frame_done = 1'b0;
        frame_word = {shift, din_s};
        unique case (state)
            ST_OFF:
            begin
                next_cnt = CNT_ZERO;
                if (!ext_n_s)
                begin
                    next_state = ST_ON;
                end
            end
            ST_ON:
            begin
                if (ext_n_s)
                begin
                    next_state = ST_OFF;
                    next_cnt = CNT_ZERO;
                end
                else if (sel_n_s)
                begin
                    next_cnt = CNT_ZERO;
                end
                else if (sclk_rise)
                begin
                    next_shift = frame_word[SHIFT_W-1:0];
                    next_cnt = cnt + CNT_ONE;
                    frame_done = (cnt == LAST_BIT);
                end
            end
        endcase
        if (!i_rst_b)
        begin
            next_sclk_d = 1'b0;
            next_state = ST_OFF;
            next_cnt = CNT_ZERO;
            next_shift = '0;
        end
    end

    // Registers of the framing group.
    always_ff @(posedge i_core_clk)
    begin
        sclk_d <= next_sclk_d;
        state <= next_state;
        cnt <= next_cnt;
        shift <= next_shift;
    end

    // Field split of a completed frame.
    assign frame_hdr = frame_word[HDR_MSB:HDR_LSB];
    assign frame_addr = frame_word[ADDR_MSB:ADDR_LSB];
    assign frame_data = frame_word[DATA_MSB:DATA_LSB];
    assign frame_slot = slot_of(frame_addr);
    assign frame_ok = frame_done && (frame_hdr == HEADER)
        && (frame_slot != NO_SLOT);

    // Register bank.  Outside extended mode it is held at the defaults, so
    // the contents steer nothing and entry into the mode starts from them.
    always_comb
    begin
        next_regs = regs;
        next_cal_start = 1'b0;
        next_ext_active = (state == ST_ON);
        if (ext_n_s || !i_rst_b)
        begin
            next_regs[SLOT_CAL] = CAL_DEFAULT;
            next_regs[SLOT_CFG] = CFG_DEFAULT;
            next_regs[SLOT_I_OFS] = OFS_DEFAULT;
            next_regs[SLOT_I_FS] = FS_DEFAULT;
            next_regs[SLOT_EXT] = EXT_DEFAULT;
            next_regs[SLOT_Q_OFS] = OFS_DEFAULT;
            next_regs[SLOT_Q_FS] = FS_DEFAULT;
            next_regs[SLOT_PH_FINE] = PH_FINE_DEFAULT;
            next_regs[SLOT_PH_COARSE] = PH_COARSE_DEFAULT;
            next_ext_active = 1'b0;
        end
        else if (frame_ok && state == ST_ON)
        begin
            next_regs[frame_slot] = frame_data;
            next_cal_start = (frame_slot == SLOT_CAL)
                && frame_data[CAL_START_BIT];
        end
    end

    // Registers of the bank; there is no readback path at all.
    always_ff @(posedge i_core_clk)
    begin
        regs <= next_regs;
        o_cal_start <= next_cal_start;
        o_ext_active <= next_ext_active;
    end

    // Register outputs come straight from the bank flip-flops.
    assign o_calibration_control = regs[SLOT_CAL];
    assign o_output_configuration = regs[SLOT_CFG];
    assign o_chan_i_offset_trim = regs[SLOT_I_OFS];
    assign o_chan_i_fullscale_trim = regs[SLOT_I_FS];
    assign o_extended_configuration = regs[SLOT_EXT];
    assign o_chan_q_offset_trim = regs[SLOT_Q_OFS];
    assign o_chan_q_fullscale_trim = regs[SLOT_Q_FS];
    assign o_sample_phase_fine = regs[SLOT_PH_FINE];
    assign o_sample_phase_coarse_mid = regs[SLOT_PH_COARSE];

    // Whole-bank view for stability checks.
    logic [NUM_REGS*DATA_BITS-1:0] bank_flat;
    assign bank_flat = {regs[SLOT_CAL], regs[SLOT_CFG], regs[SLOT_I_OFS],
        regs[SLOT_I_FS], regs[SLOT_EXT], regs[SLOT_Q_OFS], regs[SLOT_Q_FS],
        regs[SLOT_PH_FINE], regs[SLOT_PH_COARSE]};

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    // Pin-controlled mode keeps the counter idle.
    a_ignore_off_mode: assert property (
        ext_n_s |=> (cnt == CNT_ZERO)
    ) else $error("counter moved outside extended mode");

    // Each qualified edge advances the bit count by one.
    a_edge_counts: assert property (
        (state == ST_ON && !ext_n_s && !sel_n_s && sclk_rise)
        |=> (cnt == $past(cnt) + CNT_ONE)
    ) else $error("serial edge not counted");

    // A frame completes only on the 32nd counted edge.
    a_frame_length: assert property (
        frame_done |-> (cnt == LAST_BIT && sclk_rise)
    ) else $error("frame ended at the wrong bit");

    // A bad header leaves every register unchanged.
    a_header_check: assert property (
        (frame_done && frame_hdr != HEADER && !ext_n_s)
        |=> $stable(bank_flat)
    ) else $error("bad header changed a register");

    // A good frame to the configuration address lands there.
    a_value_stored: assert property (
        (frame_ok && state == ST_ON && !ext_n_s
            && frame_addr == ADDR_CFG)
        |=> (o_output_configuration == $past(frame_data))
    ) else $error("frame value not stored");

    // The next frame begins at once with select still low.
    a_back_to_back: assert property (
        (frame_done && !ext_n_s)
        |=> (cnt == CNT_ZERO && state == ST_ON)
    ) else $error("back-to-back frame not restarted");

    // Reserved addresses write nothing.
    a_reserved_addr: assert property (
        (frame_done && frame_slot == NO_SLOT && !ext_n_s)
        |=> $stable(bank_flat)
    ) else $error("reserved address changed a register");

    // Releasing select throws away a partial frame.  A mode exit in the
    // following cycle legitimately reloads the defaults, so it is excused.
    a_abort_discard: assert property (
        (state == ST_ON && sel_n_s && !ext_n_s)
        |=> (cnt == CNT_ZERO) ##1 ($stable(bank_flat) || $past(ext_n_s))
    ) else $error("partial frame survived select release");

    // Out of extended mode five of the nine outputs show the defaults two cycles on.
    a_defaults_held: assert property (
        ext_n_s [*2]
        |-> (o_output_configuration == CFG_DEFAULT
            && o_chan_i_fullscale_trim == FS_DEFAULT
            && o_chan_q_offset_trim == OFS_DEFAULT
            && o_extended_configuration == EXT_DEFAULT
            && o_sample_phase_fine == PH_FINE_DEFAULT)
    ) else $error("defaults not held in pin mode");

    // A calibration pulse follows a write with the start bit set.
    a_cal_pulse: assert property (
        o_cal_start |-> o_calibration_control[CAL_START_BIT]
            && $past(frame_slot) == SLOT_CAL && $past(frame_ok)
    ) else $error("calibration pulse without its write");

    c_cal_write: cover property (o_cal_start);
    c_back_to_back: cover property (
        frame_done ##[1:400] frame_done);
    c_abort: cover property (
        (state == ST_ON && !sel_n_s && cnt != CNT_ZERO) ##1 sel_n_s);
    c_bad_header: cover property (frame_done && frame_hdr != HEADER);

endmodule

`default_nettype wire

// ==== design/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for one pin; only stage two is visible outside.
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_level
);

    logic meta;
    logic next_meta;
    logic next_level;

    // The first stage feeds the second stage and nothing else.
    always_comb
    begin
        next_meta = i_pin;
        next_level = meta;
        if (!i_rst_b)
        begin
            next_meta = RESET_VAL;
            next_level = RESET_VAL;
        end
    end

    // Registers only.
    always_ff @(posedge i_core_clk)
    begin
        meta <= next_meta;
        o_level <= next_level;
    end

endmodule

`default_nettype wire

// ==== pkg/adc_cfg_pkg.sv ====
package adc_cfg_pkg;

    // Frame layout: header, address, then value, most significant bit first.
    localparam int FRAME_BITS = 32;
    localparam int HDR_BITS = 12;
    localparam int ADDR_BITS = 4;
    localparam int DATA_BITS = 16;
    localparam int CNT_W = 5;
    localparam int SHIFT_W = FRAME_BITS - 1;
    localparam int HDR_MSB = 31;
    localparam int HDR_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h1F;
    localparam logic [HDR_BITS-1:0] HEADER = 12'h001;

    // Register addresses carried in the frame.
    localparam logic [ADDR_BITS-1:0] ADDR_CAL = 4'h0;
    localparam logic [ADDR_BITS-1:0] ADDR_CFG = 4'h1;
    localparam logic [ADDR_BITS-1:0] ADDR_I_OFS = 4'h2;
    localparam logic [ADDR_BITS-1:0] ADDR_I_FS = 4'h3;
    localparam logic [ADDR_BITS-1:0] ADDR_EXT = 4'h9;
    localparam logic [ADDR_BITS-1:0] ADDR_Q_OFS = 4'hA;
    localparam logic [ADDR_BITS-1:0] ADDR_Q_FS = 4'hB;
    localparam logic [ADDR_BITS-1:0] ADDR_PH_FINE = 4'hE;
    localparam logic [ADDR_BITS-1:0] ADDR_PH_COARSE = 4'hF;

    // Storage slots of the nine registers; NO_SLOT marks reserved addresses.
    localparam int NUM_REGS = 9;
    localparam int SLOT_W = 4;
    localparam logic [SLOT_W-1:0] SLOT_CAL = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_CFG = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_I_OFS = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_I_FS = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_EXT = 4'h4;
    localparam logic [SLOT_W-1:0] SLOT_Q_OFS = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_Q_FS = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_PH_FINE = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_PH_COARSE = 4'h8;
    localparam logic [SLOT_W-1:0] NO_SLOT = 4'hF;

    // Extended-mode default contents.
    localparam logic [DATA_BITS-1:0] CAL_DEFAULT = 16'h7FFF;
    localparam logic [DATA_BITS-1:0] CFG_DEFAULT = 16'hB2FF;
    localparam logic [DATA_BITS-1:0] OFS_DEFAULT = 16'h007F;
    localparam logic [DATA_BITS-1:0] FS_DEFAULT = 16'h807F;
    localparam logic [DATA_BITS-1:0] EXT_DEFAULT = 16'h03FF;
    localparam logic [DATA_BITS-1:0] PH_FINE_DEFAULT = 16'h00FF;
    localparam logic [DATA_BITS-1:0] PH_COARSE_DEFAULT = 16'h007F;

    // Command bit that launches a calibration.
    localparam int CAL_START_BIT = 15;

    // Port state machine.
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_ON = 2'b10
    } frame_state_t;

endpackage

// ==== sim/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// Host side of the three-wire port; its serial clock stands still between
// frames and it only ever drives whole or deliberately cut-short frames.
module host_model (
    input wire logic i_core_clk,
    output logic o_ser_clk,
    output logic o_ser_din,
    output logic o_ser_select_n
);

    // Idle state: deselected, clock parked low.
    initial
    begin
        o_ser_clk = 1'b0;
        o_ser_din = 1'b0;
        o_ser_select_n = 1'b1;
    end

    // All pin changes land on the falling core edge, away from sampling.
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // Shifts nbits of frame, first bit at position 31; a 160 ns clock with
    // data set two core cycles before the rise and held two after the fall.
    task automatic send(input logic [31:0] frame, input int nbits,
                        input logic rel);
        int i;
        wait_cyc(1);
        o_ser_select_n = 1'b0;
        for (i = 31; i > 31 - nbits; i--)
        begin
            o_ser_din = frame[i];
            wait_cyc(2);
            o_ser_clk = 1'b1;
            wait_cyc(4);
            o_ser_clk = 1'b0;
            wait_cyc(2);
        end
        // Released data shows the inverse, so no stale bit is mistaken.
        if (rel)
        begin
            o_ser_select_n = 1'b1;
            o_ser_din = ~o_ser_din;
        end
    endtask

endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin $display("unexpected %s exp %h got %h", nm, ex, gt); fail_count++; end end

module tb_top;
    import adc_cfg_pkg::*;

    logic i_core_clk;
    logic i_rst_b;
    logic i_ext_mode_n;
    wire logic ser_clk;
    wire logic ser_din;
    wire logic ser_select_n;
    logic [15:0] got [9];
    logic [15:0] exp_reg [9];
    logic cal_start;
    logic ext_active;
    int fail_count = 0;
    int n_checks = 0;
    int cal_pulses = 0;
    int i;

    adc_serial_config_port adc_serial_config_port_inst (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_ser_clk(ser_clk),
        .i_ser_din(ser_din),
        .i_ser_select_n(ser_select_n),
        .i_ext_mode_n(i_ext_mode_n),
        .o_calibration_control(got[0]),
        .o_output_configuration(got[1]),
        .o_chan_i_offset_trim(got[2]),
        .o_chan_i_fullscale_trim(got[3]),
        .o_extended_configuration(got[4]),
        .o_chan_q_offset_trim(got[5]),
        .o_chan_q_fullscale_trim(got[6]),
        .o_sample_phase_fine(got[7]),
        .o_sample_phase_coarse_mid(got[8]),
        .o_cal_start(cal_start),
        .o_ext_active(ext_active)
    );

    host_model host_model_inst (
        .i_core_clk(i_core_clk),
        .o_ser_clk(ser_clk),
        .o_ser_din(ser_din),
        .o_ser_select_n(ser_select_n)
    );

    // 50 MHz core clock.
    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    // The start pulse lasts one cycle, so it is counted at every edge.
    always @(posedge i_core_clk)
    begin
        if (cal_start === 1'b1)
            cal_pulses++;
    end

    task automatic summarize();
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] frm(logic [3:0] a, logic [15:0] d);
        return {12'h001, a, d};
    endfunction

    // Storage slot of an address, or -1 where the address is reserved.
    function automatic int slot(logic [3:0] a);
        case (a)
            4'h0: return 0;
            4'h1: return 1;
            4'h2: return 2;
            4'h3: return 3;
            4'h9: return 4;
            4'hA: return 5;
            4'hB: return 6;
            4'hE: return 7;
            4'hF: return 8;
            default: return -1;
        endcase
    endfunction

    task automatic set_defaults();
        exp_reg = '{16'h7FFF, 16'hB2FF, 16'h007F, 16'h807F, 16'h03FF,
                    16'h007F, 16'h807F, 16'h00FF, 16'h007F};
    endtask

    // Register outputs settle three core cycles after the last rise.
    task automatic check_regs();
        int k;
        repeat (6) @(negedge i_core_clk);
        for (k = 0; k < 9; k++)
            `CHK($sformatf("reg%0d", k), exp_reg[k], got[k])
    endtask

    // One full write with the expectation updated from the address map.
    task automatic wr(logic [3:0] a, logic [15:0] d, logic rel);
        host_model_inst.send(frm(a, d), 32, rel);
        if (slot(a) >= 0)
            exp_reg[slot(a)] = d;
    endtask

    task automatic wait_active(logic lvl);
        int n;
        for (n = 0; n < 40 && ext_active !== lvl; n++)
            @(negedge i_core_clk);
        `CHK("ext_active", lvl, ext_active)
        if (ext_active !== lvl)
            summarize();
    endtask

    initial
    begin
        #1000000;
        fail_count++;
        summarize();
    end

    initial
    begin
        i_rst_b = 1'b0;
        i_ext_mode_n = 1'b0;
        repeat (16) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        set_defaults();
        wait_active(1'b1);
        check_regs();
        // All nine back to back, select held low throughout.  The start
        // bit stays clear here: no frame may follow a calibration launch.
        for (i = 0; i < 16; i++)
            if (slot(i[3:0]) >= 0)
                wr(i[3:0], 16'h25C3 ^ {i[3:0], 12'h5A1}, 1'b0);
        check_regs();
        `CHK("cal_none", 0, cal_pulses)
        // Reserved addresses change nothing.
        for (i = 0; i < 16; i++)
            if (slot(i[3:0]) < 0)
                wr(i[3:0], 16'hFFFF, 1'b0);
        check_regs();
        // Headers that are one bit off.
        host_model_inst.send({12'h003, 4'h1, 16'h1234}, 32, 1'b0);
        host_model_inst.send({12'h801, 4'h2, 16'h4321}, 32, 1'b1);
        check_regs();
        // A cut-short frame, then a whole one on a fresh select.
        host_model_inst.send(frm(4'h3, 16'h0F0F), 20, 1'b1);
        check_regs();
        wr(4'hE, 16'h8001, 1'b1);
        check_regs();
        // Calibration command with and without the start bit.
        cal_pulses = 0;
        wr(4'h0, 16'h7FFF, 1'b0);
        check_regs();
        `CHK("cal_idle", 0, cal_pulses)
        wr(4'h0, 16'hFFFF, 1'b1);
        check_regs();
        `CHK("cal_pulse", 1, cal_pulses)
        // No frame while the calibration would be running.
        repeat (200) @(negedge i_core_clk);
        // Pin-controlled mode: defaults forced, frames ignored.
        i_ext_mode_n = 1'b1;
        wait_active(1'b0);
        set_defaults();
        check_regs();
        host_model_inst.send(frm(4'h1, 16'h0000), 32, 1'b1);
        check_regs();
        i_ext_mode_n = 1'b0;
        wait_active(1'b1);
        check_regs();
        wr(4'hB, 16'h1357, 1'b1);
        check_regs();
        summarize();
    end

endmodule
`default_nettype wire
